//--- hdl/position_gear_scaler_consts.vh
// Constants for the position gear scaler
`ifndef POSITION_GEAR_SCALER_CONSTS_VH
`define POSITION_GEAR_SCALER_CONSTS_VH

// ----------------------------------------------------------------
// Setting reset values and limits
// ----------------------------------------------------------------
`define NUMERATOR_RESET      32'h0000_0001
`define DENOMINATOR_RESET    32'h0000_0001
`define GEAR_SETTING_MAX     32'h7fff_ffff

// ----------------------------------------------------------------
// Parameter port select codes
// ----------------------------------------------------------------
`define SEL_NUMERATOR        1'b0
`define SEL_DENOMINATOR      1'b1

// ----------------------------------------------------------------
// Object dictionary addressing
// ----------------------------------------------------------------
`define OD_GEAR_INDEX        16'h6091
`define OD_SUB_NUMERATOR     8'h01
`define OD_SUB_DENOMINATOR   8'h02

// ----------------------------------------------------------------
// Position unit codes and unit scale factors
// ----------------------------------------------------------------
`define UNIT_MM              2'h0
`define UNIT_INCH            2'h1
`define UNIT_DEGREE          2'h2
`define UNIT_PULSE           2'h3
`define ALPHA_MM             14'd1000
`define ALPHA_INCH           14'd10000
`define ALPHA_ONE            14'd1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        25
`define ALARM_WINDOW_NS      1000000
`define ALARM_WINDOW_CYCLES  (`ALARM_WINDOW_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/gear_divider.v
// Unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module gear_divider
#(
    parameter DW = 80,
    parameter VW = 48,
    parameter CW = 7
)
(
    input  wire          clk_in,
    input  wire          rst_n_in,
    input  wire          start_in,
    input  wire [DW-1:0] dividend_in,
    input  wire [VW-1:0] divisor_in,
    output reg           done_out,
    output reg  [DW-1:0] quotient_out,
    output reg  [VW-1:0] remainder_out
);

    localparam [31:0] DW_BITS = DW;

    reg  [CW-1:0] count_reg;
    reg           busy_reg;
    reg  [VW:0]   part_reg;
    reg  [VW-1:0] divisor_reg;
    wire [VW:0]   shifted;
    wire [VW:0]   diff;

    assign shifted = {part_reg[VW-1:0], quotient_out[DW-1]};
    assign diff    = shifted - {1'b0, divisor_reg};

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_reg     <= {CW{1'b0}};
            busy_reg      <= 1'b0;
            part_reg      <= {(VW+1){1'b0}};
            divisor_reg   <= {VW{1'b0}};
            done_out      <= 1'b0;
            quotient_out  <= {DW{1'b0}};
            remainder_out <= {VW{1'b0}};
        end
        else
        begin
            done_out <= 1'b0;
            if (start_in && !busy_reg)
            begin
                busy_reg     <= 1'b1;
                count_reg    <= DW_BITS[CW-1:0];
                part_reg     <= {(VW+1){1'b0}};
                divisor_reg  <= divisor_in;
                quotient_out <= dividend_in;
            end
            else if (busy_reg)
            begin
                if (diff[VW])
                begin
                    part_reg     <= shifted;
                    quotient_out <= {quotient_out[DW-2:0], 1'b0};
                end
                else
                begin
                    part_reg     <= diff;
                    quotient_out <= {quotient_out[DW-2:0], 1'b1};
                end
                count_reg <= count_reg - 1'b1;
                if (count_reg == {{(CW-1){1'b0}}, 1'b1})
                begin
                    busy_reg      <= 1'b0;
                    done_out      <= 1'b1;
                    remainder_out <= diff[VW] ? shifted[VW-1:0] : diff[VW-1:0];
                end
            end
        end
    end

endmodule // gear_divider

//--- hdl/position_gear_scaler.v
// Electronic gear: scales commands by num/(den*alpha) and feedback by den*alpha/num, alpha being the unit scale
`timescale 1ns/10ps
`include "position_gear_scaler_consts.vh"
module position_gear_scaler
#(
    parameter ALARM_WINDOW    = `ALARM_WINDOW_CYCLES,
    parameter FREQ_LIMIT      = 48'h0000_0010_0000,
    parameter OVERSPEED_LIMIT = 48'h0000_1000_0000
)
(
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        param_wr_in,
    input  wire        param_sel_in,
    input  wire [31:0] param_data_in,
    input  wire        od_wr_in,
    input  wire [15:0] od_index_in,
    input  wire [7:0]  od_sub_in,
    input  wire [31:0] od_data_in,
    input  wire [1:0]  position_unit_select_in,
    input  wire        cmd_valid_in,
    input  wire [31:0] cmd_pos_in,
    input  wire        fb_valid_in,
    input  wire [31:0] fb_pos_in,
    input  wire        alarm_clear_in,
    output reg         cmd_ready_out,
    output reg         fb_ready_out,
    output reg         ref_valid_out,
    output reg  [31:0] ref_pos_out,
    output reg         fbo_valid_out,
    output reg  [31:0] fbo_pos_out,
    output reg  [31:0] gear_numerator_value_out,
    output reg  [31:0] gear_denominator_value_out,
    output reg         setting_reject_out,
    output reg         overspeed_alarm_out,
    output reg         command_frequency_alarm_out
);

    localparam S_IDLE = 2'h0;
    localparam S_DIV  = 2'h1;
    localparam S_FIX  = 2'h2;

    // ----------------------------------------------------------------
    // Gear settings
    // ----------------------------------------------------------------
    reg        wr_en;
    reg        wr_sel;
    reg [31:0] wr_data;

    always @*
    begin
        wr_en   = 1'b0;
        wr_sel  = `SEL_NUMERATOR;
        wr_data = param_data_in;
        if (param_wr_in)
        begin
            wr_en  = 1'b1;
            wr_sel = param_sel_in;
        end
        else if (od_wr_in && od_index_in == `OD_GEAR_INDEX &&
                 (od_sub_in == `OD_SUB_NUMERATOR || od_sub_in == `OD_SUB_DENOMINATOR))
        begin
            wr_en   = 1'b1;
            wr_sel  = (od_sub_in == `OD_SUB_DENOMINATOR) ? `SEL_DENOMINATOR : `SEL_NUMERATOR;
            wr_data = od_data_in;
        end
    end

    // Zero would divide by zero; out-of-range is refused
    wire wr_bad = (wr_data == 32'h0000_0000) || (wr_data > `GEAR_SETTING_MAX);

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gear_numerator_value_out   <= `NUMERATOR_RESET;
            gear_denominator_value_out <= `DENOMINATOR_RESET;
            setting_reject_out         <= 1'b0;
        end
        else
        begin
            setting_reject_out <= wr_en && wr_bad;
            if (wr_en && !wr_bad && wr_sel == `SEL_NUMERATOR)
                gear_numerator_value_out <= wr_data;
            if (wr_en && !wr_bad && wr_sel == `SEL_DENOMINATOR)
                gear_denominator_value_out <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Unit scale of the travel term
    // ----------------------------------------------------------------
    reg [13:0] alpha;

    always @*
    begin
        case (position_unit_select_in)
            `UNIT_MM:     alpha = `ALPHA_MM;
            `UNIT_INCH:   alpha = `ALPHA_INCH;
            `UNIT_DEGREE: alpha = `ALPHA_ONE;
            `UNIT_PULSE:  alpha = `ALPHA_ONE;
            default:      alpha = `ALPHA_ONE;
        endcase
    end

    // Degree mode: machine teeth over motor teeth, no travel scale
    wire [47:0] den_eff = {16'h0000, gear_denominator_value_out} * {34'h0, alpha};
    wire [47:0] num_eff = {16'h0000, gear_numerator_value_out};

    // ----------------------------------------------------------------
    // Signed dividend with carried remainder
    // ----------------------------------------------------------------
    reg  [1:0]  state_reg;
    reg         turn_reg;
    reg         is_fb_reg;
    reg         neg_reg;
    reg         start_reg;
    reg  [47:0] divisor_reg;
    reg  [79:0] mag_reg;
    reg  [47:0] cmd_rem_reg;
    reg  [47:0] fb_rem_reg;

    wire        take_cmd = cmd_valid_in && cmd_ready_out;
    wire        take_fb  = fb_valid_in && fb_ready_out;
    wire [79:0] cmd_ext  = {{48{cmd_pos_in[31]}}, cmd_pos_in};
    wire [79:0] fb_ext   = {{48{fb_pos_in[31]}}, fb_pos_in};
    wire [79:0] cmd_prod = cmd_ext * {32'h0000_0000, num_eff};
    wire [79:0] fb_prod  = fb_ext * {32'h0000_0000, den_eff};
    wire [79:0] cmd_x    = cmd_prod + {32'h0000_0000, cmd_rem_reg};
    wire [79:0] fb_x     = fb_prod + {32'h0000_0000, fb_rem_reg};
    wire [79:0] sel_x    = take_cmd ? cmd_x : fb_x;
    wire [79:0] sel_mag  = sel_x[79] ? (80'h0 - sel_x) : sel_x;

    wire        div_done;
    wire [79:0] div_q;
    wire [47:0] div_r;

    gear_divider #(
        .DW (80),
        .VW (48),
        .CW (7)
    ) u_divider (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .start_in      (start_reg),
        .dividend_in   (mag_reg),
        .divisor_in    (divisor_reg),
        .done_out      (div_done),
        .quotient_out  (div_q),
        .remainder_out (div_r)
    );

    // Floor division so the remainder is never negative
    wire        r_nz    = (div_r != 48'h0);
    wire [79:0] q_neg   = 80'h0 - div_q - {79'h0, r_nz};
    wire [79:0] q_fix   = neg_reg ? q_neg : div_q;
    wire [47:0] r_fix   = (neg_reg && r_nz) ? (divisor_reg - div_r) : div_r;

    // ----------------------------------------------------------------
    // Sequencer: one request at a time, readies take turns
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg     <= S_IDLE;
            turn_reg      <= 1'b0;
            is_fb_reg     <= 1'b0;
            neg_reg       <= 1'b0;
            start_reg     <= 1'b0;
            divisor_reg   <= 48'h0;
            mag_reg       <= 80'h0;
            cmd_rem_reg   <= 48'h0;
            fb_rem_reg    <= 48'h0;
            cmd_ready_out <= 1'b0;
            fb_ready_out  <= 1'b0;
            ref_valid_out <= 1'b0;
            ref_pos_out   <= 32'h0;
            fbo_valid_out <= 1'b0;
            fbo_pos_out   <= 32'h0;
        end
        else
        begin
            start_reg     <= 1'b0;
            ref_valid_out <= 1'b0;
            fbo_valid_out <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (take_cmd || take_fb)
                    begin
                        is_fb_reg     <= take_fb;
                        neg_reg       <= sel_x[79];
                        mag_reg       <= sel_mag;
                        divisor_reg   <= take_cmd ? den_eff : num_eff;
                        start_reg     <= 1'b1;
                        cmd_ready_out <= 1'b0;
                        fb_ready_out  <= 1'b0;
                        state_reg     <= S_DIV;
                    end
                    else
                    begin
                        turn_reg      <= ~turn_reg;
                        cmd_ready_out <= turn_reg;
                        fb_ready_out  <= ~turn_reg;
                    end
                end
                S_DIV:
                begin
                    if (div_done)
                        state_reg <= S_FIX;
                end
                S_FIX:
                begin
                    if (is_fb_reg)
                    begin
                        fbo_valid_out <= 1'b1;
                        fbo_pos_out   <= q_fix[31:0];
                        fb_rem_reg    <= r_fix;
                    end
                    else
                    begin
                        ref_valid_out <= 1'b1;
                        ref_pos_out   <= q_fix[31:0];
                        cmd_rem_reg   <= r_fix;
                    end
                    turn_reg      <= ~turn_reg;
                    cmd_ready_out <= turn_reg;
                    fb_ready_out  <= ~turn_reg;
                    state_reg     <= S_IDLE;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Rate alarms over a fixed window
    // ----------------------------------------------------------------
    reg  [31:0] win_cnt_reg;
    reg  [47:0] in_sum_reg;
    reg  [47:0] out_sum_reg;

    wire        win_end  = (win_cnt_reg == ALARM_WINDOW - 1);
    wire [31:0] in_abs   = cmd_pos_in[31] ? (32'h0 - cmd_pos_in) : cmd_pos_in;
    wire [31:0] out_abs  = ref_pos_out[31] ? (32'h0 - ref_pos_out) : ref_pos_out;
    wire [47:0] in_next  = in_sum_reg + (take_cmd ? {16'h0, in_abs} : 48'h0);
    wire [47:0] out_next = out_sum_reg + (ref_valid_out ? {16'h0, out_abs} : 48'h0);

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            win_cnt_reg                 <= 32'h0;
            in_sum_reg                  <= 48'h0;
            out_sum_reg                 <= 48'h0;
            overspeed_alarm_out         <= 1'b0;
            command_frequency_alarm_out <= 1'b0;
        end
        else
        begin
            win_cnt_reg <= win_end ? 32'h0 : win_cnt_reg + 32'h1;
            in_sum_reg  <= win_end ? 48'h0 : in_next;
            out_sum_reg <= win_end ? 48'h0 : out_next;
            // Set wins over clear
            if (win_end && in_next > FREQ_LIMIT)
                command_frequency_alarm_out <= 1'b1;
            else if (alarm_clear_in)
                command_frequency_alarm_out <= 1'b0;
            if (win_end && out_next > OVERSPEED_LIMIT)
                overspeed_alarm_out <= 1'b1;
            else if (alarm_clear_in)
                overspeed_alarm_out <= 1'b0;
        end
    end

endmodule // position_gear_scaler

//--- bench/gear_cmd_source.sv
// Motion controller model issuing position commands
`timescale 1ns/10ps
module gear_cmd_source (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        go_in,
    input  wire [31:0] pos_in,
    input  wire [3:0]  lag_in,
    input  wire        cmd_ready_in,
    output reg         cmd_valid_out,
    output reg  [31:0] cmd_pos_out
);
    reg        taken_reg;
    reg        busy_reg;
    reg [3:0]  lag_reg;
    reg [31:0] hold_reg;

    always @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
            taken_reg <= 1'b0;
        else
            taken_reg <= cmd_valid_out && cmd_ready_in;

    // ----
    // Launch after a lag, hold until taken, scramble data when idle
    // ----
    always @(negedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            cmd_valid_out <= 1'b0;
            cmd_pos_out   <= 32'h0;
            busy_reg      <= 1'b0;
            lag_reg       <= 4'h0;
            hold_reg      <= 32'h0;
        end
        else if (taken_reg)
        begin
            cmd_valid_out <= 1'b0;
            busy_reg      <= 1'b0;
            cmd_pos_out   <= ~cmd_pos_out;
        end
        else if (go_in && !busy_reg)
        begin
            busy_reg    <= 1'b1;
            lag_reg     <= lag_in;
            hold_reg    <= pos_in;
            cmd_pos_out <= ~cmd_pos_out;
        end
        else if (busy_reg && !cmd_valid_out && lag_reg == 4'h0)
        begin
            cmd_valid_out <= 1'b1;
            cmd_pos_out   <= hold_reg;
        end
        else if (!cmd_valid_out)
        begin
            lag_reg     <= lag_reg - 4'h1;
            cmd_pos_out <= ~cmd_pos_out;
        end
endmodule // gear_cmd_source

//--- bench/position_gear_scaler_chk.sv
// Port checker for the position gear scaler
`timescale 1ns/10ps
`include "position_gear_scaler_consts.vh"
module position_gear_scaler_chk (
    input wire        clk_in, rst_n_in, param_wr_in, param_sel_in, od_wr_in,
    input wire        cmd_valid_in, fb_valid_in, alarm_clear_in, cmd_ready_out, fb_ready_out,
    input wire        ref_valid_out, fbo_valid_out, setting_reject_out,
    input wire        overspeed_alarm_out, command_frequency_alarm_out,
    input wire [31:0] param_data_in, od_data_in, cmd_pos_in, fb_pos_in, ref_pos_out,
    input wire [31:0] fbo_pos_out, gear_numerator_value_out, gear_denominator_value_out,
    input wire [15:0] od_index_in,
    input wire [7:0]  od_sub_in,
    input wire [1:0]  position_unit_select_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire p_bad  = param_data_in == 32'h0 || param_data_in > `GEAR_SETTING_MAX;
    wire o_ok   = od_data_in != 32'h0 && od_data_in <= `GEAR_SETTING_MAX;
    wire od_den = !param_wr_in && od_wr_in && od_index_in == `OD_GEAR_INDEX
                  && od_sub_in == `OD_SUB_DENOMINATOR && o_ok;
    wire c_take = cmd_valid_in && cmd_ready_out;

    chk_num_reset: assert property (!$past(rst_n_in) |->
        gear_numerator_value_out == `NUMERATOR_RESET) else $error("numerator reset");
    chk_den_reset: assert property (!$past(rst_n_in) |->
        gear_denominator_value_out == `DENOMINATOR_RESET) else $error("denominator reset");
    chk_num_write: assert property (param_wr_in && !param_sel_in && !p_bad |=>
        gear_numerator_value_out == $past(param_data_in)) else $error("numerator write");
    chk_refuse_hold: assert property (param_wr_in && p_bad |=> setting_reject_out &&
        $stable(gear_numerator_value_out) && $stable(gear_denominator_value_out))
        else $error("refused write");
    chk_od_den: assert property (od_den |=>
        gear_denominator_value_out == $past(od_data_in)) else $error("object write");
    chk_ref_latency: assert property (c_take |-> ##84 ref_valid_out)
        else $error("reference latency");
    chk_busy_quiet: assert property (c_take |=> (!cmd_ready_out && !fb_ready_out)[*8])
        else $error("ready while busy");
    chk_fb_latency: assert property (fb_valid_in && fb_ready_out |-> ##84 fbo_valid_out)
        else $error("feedback latency");
    chk_alarm_sticky: assert property (overspeed_alarm_out && !alarm_clear_in |=>
        overspeed_alarm_out) else $error("alarm dropped");
    chk_ref_hold: assert property (!ref_valid_out |-> $stable(ref_pos_out))
        else $error("reference moved");

    cov_cmd: cover property (c_take);
    cov_reject: cover property (setting_reject_out);
    cov_alarm: cover property ($rose(command_frequency_alarm_out));
endmodule // position_gear_scaler_chk

bind position_gear_scaler position_gear_scaler_chk u_chk (.*);

//--- bench/position_gear_scaler_tb.sv
// Self-checking bench for the position gear scaler
`timescale 1ns/10ps
`include "position_gear_scaler_consts.vh"
module position_gear_scaler_tb;
    reg         clk_in = 0, rst_n_in = 0, param_wr_in = 0, param_sel_in = 0, go = 0;
    reg         od_wr_in = 0, fb_valid_in = 0, alarm_clear_in = 0;
    reg  [31:0] param_data_in = 0, od_data_in = 0, fb_pos_in = 0, go_pos = 0, seed;
    reg  [15:0] od_index_in = 16'h0;
    reg  [7:0]  od_sub_in = 8'h0;
    reg  [1:0]  position_unit_select_in = 2'h3;
    reg  [3:0]  lag = 4'h0;
    wire        cmd_valid_in, cmd_ready_out, fb_ready_out, ref_valid_out, fbo_valid_out;
    wire        setting_reject_out, overspeed_alarm_out, command_frequency_alarm_out;
    wire [31:0] cmd_pos_in, ref_pos_out, fbo_pos_out;
    wire [31:0] gear_numerator_value_out, gear_denominator_value_out;
    integer     num_errors = 0, total_checks = 0, i, u;
    longint     num_m = 1, den_m = 1, rc = 0, rf = 0;

    always #12.5 clk_in = ~clk_in;

    position_gear_scaler #(.ALARM_WINDOW(64), .FREQ_LIMIT(48'h0000_0100_0000),
        .OVERSPEED_LIMIT(48'h0000_0800_0000)) DUT (.*);
    gear_cmd_source u_src (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .pos_in(go_pos),
        .lag_in(lag), .cmd_ready_in(cmd_ready_out), .cmd_valid_out(cmd_valid_in),
        .cmd_pos_out(cmd_pos_in));

    // ----
    // Helpers
    // ----
    task close_out;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task chk32(input [31:0] got, input [31:0] exp);
        begin
            total_checks++;
            if (got !== exp)
            begin
                num_errors++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Bounded wait: 0 reference, 1 feedback, 2 both alarms
    task wait_flag(input integer w);
        integer n;
        begin
            n = 0;
            while (n < 400 && (w == 0 ? ref_valid_out : w == 1 ? fbo_valid_out
                   : overspeed_alarm_out & command_frequency_alarm_out) !== 1'b1)
            begin
                @(posedge clk_in);
                #1;
                n++;
            end
            if (n == 400)
            begin
                num_errors++;
                $display("MISMATCH t=%0t timeout", $time);
                close_out;
            end
        end
    endtask

    function automatic longint alpha(input [1:0] s);
        alpha = s == `UNIT_MM ? 1000 : s == `UNIT_INCH ? 10000 : 1;
    endfunction

    task wr(input od, input [15:0] idx, input [7:0] sub, input sel, input [31:0] d);
        reg hit, ok, tsel;
        begin
            hit = !od || (idx == `OD_GEAR_INDEX && (sub == 8'h01 || sub == 8'h02));
            tsel = od ? sub == `OD_SUB_DENOMINATOR : sel;
            ok = d != 0 && d <= `GEAR_SETTING_MAX;
            @(negedge clk_in);
            param_wr_in = !od;
            param_sel_in = sel;
            param_data_in = d;
            od_wr_in = od;
            od_index_in = idx;
            od_sub_in = sub;
            od_data_in = d;
            @(negedge clk_in);
            param_wr_in = 0;
            od_wr_in = 0;
            if (hit && ok && !tsel) num_m = d;
            if (hit && ok && tsel) den_m = d;
            chk32(setting_reject_out, hit && !ok);
            chk32(gear_numerator_value_out, num_m);
            chk32(gear_denominator_value_out, den_m);
        end
    endtask

    task do_cmd(input [31:0] c);
        longint n, d, q;
        begin
            n = longint'(signed'(c)) * num_m + rc;
            d = den_m * alpha(position_unit_select_in);
            q = n / d;
            if (n % d < 0) q = q - 1;
            rc = n - q * d;
            @(negedge clk_in);
            go <= 1'b1;
            go_pos <= c;
            lag <= $urandom % 4;
            @(negedge clk_in);
            go <= 1'b0;
            wait_flag(0);
            chk32(ref_pos_out, q[31:0]);
        end
    endtask

    task do_fb(input [31:0] f);
        longint n, q;
        integer k;
        begin
            n = longint'(signed'(f)) * den_m * alpha(position_unit_select_in) + rf;
            q = n / num_m;
            if (n % num_m < 0) q = q - 1;
            rf = n - q * num_m;
            @(negedge clk_in);
            fb_valid_in = 1;
            fb_pos_in = f;
            for (k = 0; k < 400 && fb_ready_out !== 1'b1; k++) @(negedge clk_in);
            if (k == 400)
            begin
                num_errors++;
                $display("MISMATCH t=%0t no feedback ready", $time);
                close_out;
            end
            @(negedge clk_in);
            fb_valid_in = 0;
            fb_pos_in = ~f;
            wait_flag(1);
            chk32(fbo_pos_out, q[31:0]);
        end
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        seed = $urandom(7161);
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1;
        @(negedge clk_in);
        chk32(gear_numerator_value_out, 1);
        chk32(gear_denominator_value_out, 1);
        $display("Reset test done");
        wr(0, 0, 0, 0, 32'h7fff_ffff);
        wr(0, 0, 0, 0, 32'h8000_0000);
        wr(0, 0, 0, 1, 32'h0);
        wr(1, `OD_GEAR_INDEX, `OD_SUB_NUMERATOR, 0, 32'h19);
        wr(1, `OD_GEAR_INDEX, `OD_SUB_DENOMINATOR, 0, 32'hb);
        wr(1, `OD_GEAR_INDEX, 8'h03, 0, 32'h5);
        wr(1, 16'h6092, `OD_SUB_NUMERATOR, 0, 32'h5);
        $display("Settings test done");
        for (u = 0; u < 4; u++)
        begin
            @(negedge clk_in);
            position_unit_select_in = u;
            for (i = 0; i < 4; i++)
            begin
                wr(0, 0, 0, 0, 1 + $urandom % 32'h10_0000);
                wr(0, 0, 0, 1, 1 + $urandom % 32'hfff);
                do_cmd(i == 0 ? 32'h8000_0000 : i == 1 ? 32'hffff_ffff : $urandom);
                do_fb($urandom);
            end
            $display("Unit %0d test done", u);
        end
        wr(0, 0, 0, 0, 1);
        wr(0, 0, 0, 1, 1);
        // Clear first so the raised alarms come from this command alone
        for (i = 0; i < 2; i++)
        begin
            @(negedge clk_in);
            alarm_clear_in = 1;
            repeat (140) @(negedge clk_in);
            alarm_clear_in = 0;
            @(negedge clk_in);
            chk32({overspeed_alarm_out, command_frequency_alarm_out}, 2'b00);
            if (i == 0)
            begin
                do_cmd(32'h1000_0000);
                wait_flag(2);
                chk32({overspeed_alarm_out, command_frequency_alarm_out}, 2'b11);
            end
        end
        $display("Alarm test done");
        close_out;
    end
endmodule // position_gear_scaler_tb
